// >>> design/psr_consts.vh
`ifndef PSR_CONSTS_VH
`define PSR_CONSTS_VH

// Register indices; byte address is four times the index
`define PSR_IDX_CMD        6'h0D
`define PSR_IDX_PORT       6'h0E
`define PSR_IDX_FLD        6'h0F
`define PSR_IDX_STS        6'h10
`define PSR_IDX_LSB        2
`define PSR_IDX_MSB        7

// Indirect command field
`define PSR_CMD_MSB        15
`define PSR_CMD_LSB        14
`define PSR_CMD_ADDR       2'b00
`define PSR_CMD_DATA       2'b01
`define PSR_CMD_DATA_INC   2'b10
`define PSR_CMD_DATA_INCW  2'b11
`define PSR_SEL_MSB        4
`define PSR_SEL_LSB        0
`define PSR_SEL_VENDOR     5'h1F
`define PSR_SEL_SPACE3     5'h03
`define PSR_SEL_SPACE7     5'h07
`define PSR_CMD_RST        16'h0000
`define PSR_CMD_MASK       16'hC01F
`define PSR_PORT_RST       16'h0010
`define PSR_PTR_ONE        16'h0001
`define PSR_MEM_AW         5

// Link-drop cause field
`define PSR_FLD_LSB        4
`define PSR_FLD_MSB        8
`define PSR_FLD_DESCR      5'h10
`define PSR_FLD_RXERR      5'h08
`define PSR_FLD_CODING     5'h04
`define PSR_FLD_SNR        5'h02
`define PSR_FLD_ENERGY     5'h01
`define PSR_FLD_RST        5'h00

// Composite status bit positions
`define PSR_STS_RSVD       15
`define PSR_STS_MDIX       14
`define PSR_STS_RXERR      13
`define PSR_STS_POL        12
`define PSR_STS_FCAR       11
`define PSR_STS_SIGDET     10
`define PSR_STS_DLOCK      9
`define PSR_STS_PAGE       8
`define PSR_STS_INT        7
`define PSR_STS_RFAULT     6
`define PSR_STS_JABBER     5
`define PSR_STS_ANEG       4
`define PSR_STS_LOOP       3
`define PSR_STS_DUPLEX     2
`define PSR_STS_SPEED      1
`define PSR_STS_LINK       0
`define PSR_SPEED_RST      1'b1

// Receive-error link drop
`define PSR_RXERR_LIMIT    6'd32
`define PSR_WINDOW_NS      10000
`define PSR_CLK_NS         10
`define PSR_WINDOW_CYC     (`PSR_WINDOW_NS / `PSR_CLK_NS)
`define PSR_WIN_W          10
`define PSR_CNT_W          6

// Bus answers
`define PSR_RESP_OKAY      2'b00
`define PSR_RESP_DECERR    2'b11
`define PSR_ZERO16         16'h0000
`define PSR_ZERO32         32'h00000000

`endif

// >>> design/psr_ext_mem.v
`timescale 1ns/10ps
`include "psr_consts.vh"

module psr_ext_mem (
    input  wire                    aclk,
    input  wire                    we,
    input  wire [`PSR_MEM_AW-1:0]  waddr,
    input  wire [15:0]             wdata,
    input  wire [`PSR_MEM_AW-1:0]  raddr,
    output reg  [15:0]             rdata
);
    reg [15:0] mem [0:(1<<`PSR_MEM_AW)-1];

    always @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // psr_ext_mem

// >>> design/psr_regs.v
// Contract
// - Port holds target address when command is 00, else extended-space data.
// - Command 00 address, 01 data, 10 inc on read/write, 11 inc on write.
// - Each cause bit latches high when its enabled drop condition drops link.
// - Cause bits one-hot: descrambler, rx errors, coding, low SNR, energy loss.
// - With rx-error drop enabled, 32 rx errors within 10 us drop the link; code counts them per fixed 1000-cycle window.
// - Status bit 14 is 1 while pairs are swapped, 0 when normal.
// - Status bit 13 latches on rx error, clears on receive error counter read.
// - Bit 12 mirrors polarity flag, clears on its register read, not status read.
// - Bit 11 latches on false carrier, clears on false carrier counter read.
// - Bit 10 is 100M signal detect, latching low; ignore during low-power idle.
// - Bit 9 is descrambler lock, latching low; ignore during low-power idle.
// - Bit 8 duplicates page received, clears on autoneg expansion read.
// - Bit 7 latches while interrupt pending, clears on interrupt source read.
// - Bit 6 set on partner remote fault, clears on basic status read or reset.
// - Bit 5 mirrors jabber detect; status read does not clear it.
// - Bits 4..1: autoneg done, loopback, full duplex, 10M speed resetting to 1.
// - Bit 0 copies link status; status read does not clear it.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "psr_consts.vh"

module psr_regs (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        mdix_swapped,
    input  wire        rx_error_event,
    input  wire        polarity_inverted,
    input  wire        false_carrier_event,
    input  wire        signal_detect,
    input  wire        descrambler_lock,
    input  wire        page_received,
    input  wire        interrupt_pending,
    input  wire        remote_fault_event,
    input  wire        jabber_detect,
    input  wire        autoneg_complete,
    input  wire        loopback_enabled,
    input  wire        full_duplex,
    input  wire        speed_10,
    input  wire        link_up,
    input  wire        rx_err_drop_enable,
    input  wire        drop_descr_sync,
    input  wire        drop_coding_viol,
    input  wire        drop_low_snr,
    input  wire        drop_energy_loss,
    input  wire        receive_error_counter_rd,
    input  wire        ten_meg_status_control_rd,
    input  wire        false_carrier_counter_rd,
    input  wire        autoneg_expansion_rd,
    input  wire        interrupt_source_rd,
    input  wire        basic_status_reg_rd,
    output reg         link_drop_rx_err
);
    function is_data;
        input [1:0] cmd;
        is_data = (cmd != `PSR_CMD_ADDR);
    endfunction

    function sel_ok;
        input [4:0] sel;
        sel_ok = (sel == `PSR_SEL_VENDOR) || (sel == `PSR_SEL_SPACE3) ||
                 (sel == `PSR_SEL_SPACE7);
    endfunction

    function mapped;
        input [5:0] idx;
        mapped = (idx == `PSR_IDX_CMD) || (idx == `PSR_IDX_PORT) ||
                 (idx == `PSR_IDX_FLD) || (idx == `PSR_IDX_STS);
    endfunction

    function [15:0] merge;
        input [15:0] old;
        input [15:0] nw;
        input [1:0]  strb;
        merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    endfunction

    // Bus state
    reg        aw_got;
    reg        w_got;
    reg [5:0]  wr_idx;
    reg [15:0] wr_data;
    reg [1:0]  wr_strb;
    reg        rd_pend;
    reg [5:0]  rd_idx;

    // Register state
    reg [15:0] indirect_command_reg;
    reg [15:0] addr_ptr;
    reg [4:0]  link_drop_cause;
    reg [15:0] phy_composite_status;
    reg        ll_rearm;

    // Receive-error window
    reg [`PSR_WIN_W-1:0] win_cnt;
    reg [`PSR_CNT_W-1:0] err_cnt;

    wire [15:0] mem_rdata;
    wire [1:0]  cmd  = indirect_command_reg[`PSR_CMD_MSB:`PSR_CMD_LSB];
    wire [4:0]  sel  = indirect_command_reg[`PSR_SEL_MSB:`PSR_SEL_LSB];
    wire        do_wr = aw_got && w_got && !s_axi_bvalid;
    wire        do_rd = rd_pend;
    wire        wr_port_data = do_wr && (wr_idx == `PSR_IDX_PORT) && is_data(cmd);
    wire        mem_we = wr_port_data && sel_ok(sel);
    wire        rd_port = do_rd && (rd_idx == `PSR_IDX_PORT);
    wire        rd_fld = do_rd && (rd_idx == `PSR_IDX_FLD);
    wire        rd_sts = do_rd && (rd_idx == `PSR_IDX_STS);
    wire [4:0]  fld_cond = {drop_descr_sync, link_drop_rx_err, drop_coding_viol,
                            drop_low_snr, drop_energy_loss};
    wire        aw_hs = s_axi_awvalid && s_axi_awready;
    wire        w_hs  = s_axi_wvalid && s_axi_wready;
    wire        ar_hs = s_axi_arvalid && s_axi_arready;
    wire        next_aw_got = (aw_got && !do_wr) || aw_hs;
    wire        next_w_got  = (w_got && !do_wr) || w_hs;
    wire        next_bvalid = do_wr || (s_axi_bvalid && !s_axi_bready);
    wire        next_rd_pend = ar_hs;
    wire        next_rvalid = do_rd || (s_axi_rvalid && !s_axi_rready);

    psr_ext_mem u_mem (
        .aclk  (aclk),
        .we    (mem_we),
        .waddr (addr_ptr[`PSR_MEM_AW-1:0]),
        .wdata (merge(mem_rdata, wr_data, wr_strb)),
        .raddr (addr_ptr[`PSR_MEM_AW-1:0]),
        .rdata (mem_rdata)
    );

    // Write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            wr_idx        <= 6'h00;
            wr_data       <= `PSR_ZERO16;
            wr_strb       <= 2'b00;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PSR_RESP_OKAY;
        end else begin
            aw_got        <= next_aw_got;
            w_got         <= next_w_got;
            s_axi_awready <= !next_aw_got && !next_bvalid;
            s_axi_wready  <= !next_w_got && !next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            if (aw_hs) begin
                wr_idx <= s_axi_awaddr[`PSR_IDX_MSB:`PSR_IDX_LSB];
            end
            if (w_hs) begin
                wr_data <= s_axi_wdata[15:0];
                wr_strb <= s_axi_wstrb[1:0];
            end
            if (do_wr) begin
                s_axi_bresp <= mapped(wr_idx) ? `PSR_RESP_OKAY : `PSR_RESP_DECERR;
            end
        end
    end

    // Read channel: one cycle to fetch, answer the next
    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_pend       <= 1'b0;
            rd_idx        <= 6'h00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `PSR_ZERO32;
            s_axi_rresp   <= `PSR_RESP_OKAY;
        end else begin
            rd_pend       <= next_rd_pend;
            s_axi_rvalid  <= next_rvalid;
            s_axi_arready <= !next_rd_pend && !next_rvalid;
            if (ar_hs) begin
                rd_idx <= s_axi_araddr[`PSR_IDX_MSB:`PSR_IDX_LSB];
            end
            if (do_rd) begin
                s_axi_rresp <= mapped(rd_idx) ? `PSR_RESP_OKAY : `PSR_RESP_DECERR;
                case (rd_idx)
                    `PSR_IDX_CMD: begin
                        s_axi_rdata <= {16'h0000, indirect_command_reg};
                    end
                    `PSR_IDX_PORT: begin
                        if (!is_data(cmd)) begin
                            s_axi_rdata <= {16'h0000, addr_ptr};
                        end else if (sel_ok(sel)) begin
                            s_axi_rdata <= {16'h0000, mem_rdata};
                        end else begin
                            s_axi_rdata <= `PSR_ZERO32;
                        end
                    end
                    `PSR_IDX_FLD: begin
                        s_axi_rdata <= {16'h0000, 7'h00, link_drop_cause, 4'h0};
                    end
                    `PSR_IDX_STS: begin
                        s_axi_rdata <= {16'h0000, phy_composite_status};
                    end
                    default: begin
                        s_axi_rdata <= `PSR_ZERO32;
                    end
                endcase
            end
        end
    end

    // Command register and address pointer
    always @(posedge aclk) begin
        if (!aresetn) begin
            indirect_command_reg <= `PSR_CMD_RST;
            addr_ptr             <= `PSR_PORT_RST;
        end else begin
            if (do_wr && (wr_idx == `PSR_IDX_CMD)) begin
                indirect_command_reg <= merge(indirect_command_reg, wr_data, wr_strb) &
                    `PSR_CMD_MASK;
            end
            // A write in the same cycle as a read takes precedence
            if (rd_port && sel_ok(sel) && (cmd == `PSR_CMD_DATA_INC)) begin
                addr_ptr <= addr_ptr + `PSR_PTR_ONE;
            end
            if (do_wr && (wr_idx == `PSR_IDX_PORT) && !is_data(cmd)) begin
                addr_ptr <= merge(addr_ptr, wr_data, wr_strb);
            end else if (mem_we && ((cmd == `PSR_CMD_DATA_INC) ||
                                    (cmd == `PSR_CMD_DATA_INCW))) begin
                addr_ptr <= addr_ptr + `PSR_PTR_ONE;
            end
        end
    end

    // Receive errors counted over fixed windows of the drop interval
    always @(posedge aclk) begin
        if (!aresetn) begin
            win_cnt          <= {`PSR_WIN_W{1'b0}};
            err_cnt          <= {`PSR_CNT_W{1'b0}};
            link_drop_rx_err <= 1'b0;
        end else begin
            link_drop_rx_err <= 1'b0;
            if (!rx_err_drop_enable ||
                (win_cnt == `PSR_WINDOW_CYC - 1)) begin
                win_cnt <= {`PSR_WIN_W{1'b0}};
                err_cnt <= {`PSR_CNT_W{1'b0}};
            end else begin
                win_cnt <= win_cnt + 1'b1;
                if (rx_error_event) begin
                    if (err_cnt + 1'b1 == `PSR_RXERR_LIMIT) begin
                        link_drop_rx_err <= 1'b1;
                        err_cnt          <= {`PSR_CNT_W{1'b0}};
                    end else begin
                        err_cnt <= err_cnt + 1'b1;
                    end
                end
            end
        end
    end

    // Cause latch: a live condition wins over the read clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            link_drop_cause <= `PSR_FLD_RST;
        end else begin
            link_drop_cause <= (rd_fld ? `PSR_FLD_RST : link_drop_cause) | fld_cond;
        end
    end

    // Composite status
    always @(posedge aclk) begin
        if (!aresetn) begin
            phy_composite_status                 <= `PSR_ZERO16;
            phy_composite_status[`PSR_STS_SPEED] <= `PSR_SPEED_RST;
            ll_rearm                             <= 1'b1;
        end else begin
            ll_rearm <= rd_sts;
            phy_composite_status[`PSR_STS_RSVD] <= 1'b0;
            phy_composite_status[`PSR_STS_MDIX] <= mdix_swapped;
            phy_composite_status[`PSR_STS_RXERR] <= rx_error_event ||
                (phy_composite_status[`PSR_STS_RXERR] && !receive_error_counter_rd);
            phy_composite_status[`PSR_STS_POL] <= polarity_inverted ||
                (phy_composite_status[`PSR_STS_POL] && !ten_meg_status_control_rd);
            phy_composite_status[`PSR_STS_FCAR] <= false_carrier_event ||
                (phy_composite_status[`PSR_STS_FCAR] && !false_carrier_counter_rd);
            // Low-power idle is not filtered here; software discards these bits then
            phy_composite_status[`PSR_STS_SIGDET] <= signal_detect &&
                (phy_composite_status[`PSR_STS_SIGDET] || ll_rearm);
            phy_composite_status[`PSR_STS_DLOCK] <= descrambler_lock &&
                (phy_composite_status[`PSR_STS_DLOCK] || ll_rearm);
            phy_composite_status[`PSR_STS_PAGE] <= page_received ||
                (phy_composite_status[`PSR_STS_PAGE] && !autoneg_expansion_rd);
            phy_composite_status[`PSR_STS_INT] <= interrupt_pending ||
                (phy_composite_status[`PSR_STS_INT] && !interrupt_source_rd);
            phy_composite_status[`PSR_STS_RFAULT] <= remote_fault_event ||
                (phy_composite_status[`PSR_STS_RFAULT] && !basic_status_reg_rd);
            phy_composite_status[`PSR_STS_JABBER] <= jabber_detect;
            phy_composite_status[`PSR_STS_ANEG]   <= autoneg_complete;
            phy_composite_status[`PSR_STS_LOOP]   <= loopback_enabled;
            phy_composite_status[`PSR_STS_DUPLEX] <= full_duplex;
            phy_composite_status[`PSR_STS_SPEED]  <= speed_10;
            phy_composite_status[`PSR_STS_LINK]   <= link_up;
        end
    end
endmodule // psr_regs

// >>> verif/psr_regs_props.sv
`timescale 1ns/10ps
module psr_regs_props (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        rx_err_drop_enable,
    input wire        link_drop_rx_err
);
    reg  [7:0] rd_addr;
    wire       mapped;
    // Indices 0x0D to 0x10, low address bits ignored
    assign mapped = (rd_addr >= 8'h34) && (rd_addr <= 8'h43);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_addr <= 8'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_addr <= s_axi_araddr;
        end
    end
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=>
        !s_axi_arready ##[0:3] s_axi_rvalid) else $error("read answer missing");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_unmapped_rd: assert property (s_axi_rvalid && !mapped |->
        s_axi_rresp == 2'b11 && s_axi_rdata == 32'h00000000) else $error("bad unmapped read");
    a_mapped_rd: assert property (s_axi_rvalid && mapped |->
        s_axi_rresp == 2'b00 && s_axi_rdata[31:16] == 16'h0000) else $error("bad mapped read");
    a_cause_rsvd: assert property (s_axi_rvalid && rd_addr[7:2] == 6'h0F |->
        s_axi_rdata[15:9] == 7'h00 && s_axi_rdata[3:0] == 4'h0) else $error("cause spare bits");
    a_drop_pulse: assert property (link_drop_rx_err |=> !link_drop_rx_err)
        else $error("drop pulse too long");
    a_drop_enable: assert property (link_drop_rx_err |-> $past(rx_err_drop_enable))
        else $error("drop while disabled");
endmodule // psr_regs_props

// >>> verif/psr_regs_tb.sv
`timescale 1ns/10ps
`include "psr_consts.vh"
module psr_regs_tb;
    localparam [7:0]  A_CMD = 8'h34, A_PORT = 8'h38, A_FLD = 8'h3C, A_STS = 8'h40;
    localparam [29:0] LH = {5'd6, 5'd7, 5'd8, 5'd11, 5'd12, 5'd13};
    reg         aclk, aresetn, rx_en;
    reg  [7:0]  s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata, rv;
    reg  [3:0]  s_axi_wstrb, drop_src;
    reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        link_drop_rx_err;
    reg  [5:0]  set_src, clr_rd;
    reg  [1:0]  ll_src, rr;
    reg  [6:0]  mir;
    reg  [15:0] base;
    reg  [24:0] ops [0:23];
    integer     err_total, total_checks, i, k, n, cnt;
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    psr_regs u_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .link_drop_rx_err,
        .mdix_swapped(mir[6]), .jabber_detect(mir[5]), .autoneg_complete(mir[4]),
        .loopback_enabled(mir[3]), .full_duplex(mir[2]), .speed_10(mir[1]), .link_up(mir[0]),
        .rx_error_event(set_src[0]), .polarity_inverted(set_src[1]),
        .false_carrier_event(set_src[2]), .page_received(set_src[3]),
        .interrupt_pending(set_src[4]), .remote_fault_event(set_src[5]),
        .receive_error_counter_rd(clr_rd[0]), .ten_meg_status_control_rd(clr_rd[1]),
        .false_carrier_counter_rd(clr_rd[2]), .autoneg_expansion_rd(clr_rd[3]),
        .interrupt_source_rd(clr_rd[4]), .basic_status_reg_rd(clr_rd[5]),
        .signal_detect(ll_src[1]), .descrambler_lock(ll_src[0]), .rx_err_drop_enable(rx_en),
        .drop_descr_sync(drop_src[3]), .drop_coding_viol(drop_src[2]),
        .drop_low_snr(drop_src[1]), .drop_energy_loss(drop_src[0])
    );
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task hang;
        begin
            err_total = err_total + 1;
            $display("[FAIL] %0t: bus answer never came", $time);
            report_and_stop;
        end
    endtask
    // Master holds each channel until its own handshake edge
    task axi_wr(input [7:0] a, input [15:0] d, output [1:0] r);
        begin
            @(posedge aclk);
            s_axi_awaddr  <= a;
            s_axi_awvalid <= 1'b1;
            s_axi_wdata   <= {16'h0000, d};
            s_axi_wvalid  <= 1'b1;
            s_axi_bready  <= 1'b1;
            for (n = 0; n < 100; n = n + 1) begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid) begin
                    r = s_axi_bresp;
                    s_axi_bready <= 1'b0;
                    n = 200;
                end
            end
            if (n != 201) hang;
        end
    endtask
    task axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
        begin
            @(posedge aclk);
            s_axi_araddr  <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready  <= 1'b1;
            for (n = 0; n < 100; n = n + 1) begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid) begin
                    d = s_axi_rdata;
                    r = s_axi_rresp;
                    s_axi_rready <= 1'b0;
                    n = 200;
                end
            end
            if (n != 201) hang;
        end
    endtask
    // Response code rides in the upper bits so one compare covers both
    task rd_chk(input [7:0] a, input [15:0] e);
        begin
            axi_rd(a, rv, rr);
            chk({14'h0000, rr, rv[15:0]}, {16'h0000, e});
        end
    endtask
    task wr_ok(input [7:0] a, input [15:0] d);
        begin
            axi_wr(a, d, rr);
            chk({30'h00000000, rr}, 32'h00000000);
        end
    endtask
    task pulse_clr(input integer c);
        begin
            @(posedge aclk);
            clr_rd[c] <= 1'b1;
            @(posedge aclk);
            clr_rd[c] <= 1'b0;
        end
    endtask
    initial begin
        err_total = 0;
        total_checks = 0;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = 0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, set_src, clr_rd, ll_src, rx_en} = 0;
        s_axi_wstrb = 4'hF;
        drop_src = 4'h0;
        mir = 7'h02;
        {ops[0], ops[1], ops[2], ops[3]} = {1'b1, A_STS, 16'hFFFF, 1'b0, A_STS, 16'h6635,
            1'b1, A_CMD, 16'h001F, 1'b1, A_PORT, 16'h0005};
        ops[4] = {1'b0, A_PORT, 16'h0005};
        ops[5] = {1'b1, A_CMD, 16'h401F};
        ops[6] = {1'b1, A_PORT, 16'hA5A5};
        ops[7] = {1'b0, A_PORT, 16'hA5A5};
        ops[8] = {1'b1, A_CMD, 16'h801F};
        ops[9] = {1'b0, A_PORT, 16'hA5A5};
        ops[10] = {1'b1, A_PORT, 16'h1111};
        ops[11] = {1'b1, A_CMD, 16'h001F};
        ops[12] = {1'b0, A_PORT, 16'h0007};
        ops[13] = {1'b1, A_CMD, 16'hC01F};
        ops[14] = {1'b1, A_PORT, 16'h2222};
        ops[15] = {1'b1, A_CMD, 16'h001F};
        ops[16] = {1'b0, A_PORT, 16'h0008};
        ops[17] = {1'b1, A_PORT, 16'h0006};
        ops[18] = {1'b1, A_CMD, 16'hC01F};
        ops[19] = {1'b0, A_PORT, 16'h1111};
        ops[20] = {1'b0, A_PORT, 16'h1111};
        ops[21] = {1'b1, A_CMD, 16'h4002};
        ops[22] = {1'b1, A_PORT, 16'h9999};
        ops[23] = {1'b0, A_PORT, 16'h0000};
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(A_STS, 16'h0002);
        rd_chk(A_FLD, 16'h0000);
        rd_chk(A_PORT, `PSR_PORT_RST);
        rd_chk(A_CMD, `PSR_CMD_RST);
        $display("test reset values done");
        base = 16'h4635;
        mir <= 7'h75;
        ll_src <= 2'b11;
        axi_rd(A_STS, rv, rr);
        rd_chk(A_STS, base);
        mir <= 7'h0A;
        rd_chk(A_STS, 16'h060A);
        mir <= 7'h75;
        for (k = 0; k < 2; k = k + 1) begin
            @(posedge aclk);
            ll_src[k] <= 1'b0;
            @(posedge aclk);
            ll_src[k] <= 1'b1;
            rd_chk(A_STS, base & ~(16'h0200 << k));
            rd_chk(A_STS, base);
        end
        $display("test mirror and latch-low done");
        for (i = 0; i < 6; i = i + 1) begin
            @(posedge aclk);
            set_src[i] <= 1'b1;
            @(posedge aclk);
            set_src[i] <= 1'b0;
            rd_chk(A_STS, base | (16'h0001 << LH[i*5 +: 5]));
            pulse_clr((i + 1) % 6);
            rd_chk(A_STS, base | (16'h0001 << LH[i*5 +: 5]));
            pulse_clr(i);
            rd_chk(A_STS, base);
        end
        $display("test latch-high done");
        for (k = 0; k < 4; k = k + 1) begin
            @(posedge aclk);
            drop_src[k] <= 1'b1;
            @(posedge aclk);
            drop_src[k] <= 1'b0;
            rd_chk(A_FLD, 16'h0010 << (k + (k == 3)));
            rd_chk(A_FLD, 16'h0000);
        end
        drop_src[2] <= 1'b1;
        rd_chk(A_FLD, 16'h0040);
        rd_chk(A_FLD, 16'h0040);
        drop_src[2] <= 1'b0;
        rd_chk(A_FLD, 16'h0040);
        rd_chk(A_FLD, 16'h0000);
        // Long burst so a fixed window boundary cannot hide 32 errors
        for (k = 0; k < 2; k = k + 1) begin
            cnt = 0;
            @(posedge aclk);
            rx_en <= k[0];
            set_src[0] <= 1'b1;
            for (i = 0; i < 68; i = i + 1) begin
                @(posedge aclk);
                if (i == 63) set_src[0] <= 1'b0;
                if (link_drop_rx_err === 1'b1) cnt = cnt + 1;
            end
            chk({31'h00000000, cnt != 0}, {31'h00000000, k[0]});
        end
        rd_chk(A_FLD, 16'h0080);
        $display("test link-drop cause done");
        for (i = 0; i < 24; i = i + 1) begin
            if (ops[i][24]) wr_ok(ops[i][23:16], ops[i][15:0]);
            else rd_chk(ops[i][23:16], ops[i][15:0]);
        end
        wr_ok(A_CMD, 16'h4003);
        s_axi_wstrb <= 4'h1;
        wr_ok(A_PORT, 16'hABCD);
        s_axi_wstrb <= 4'hF;
        rd_chk(A_PORT, 16'h11CD);
        axi_rd(8'h44, rv, rr);
        chk({rr, rv[29:0]}, 32'hC0000000);
        axi_wr(8'h30, 16'hFFFF, rr);
        chk({30'h00000000, rr}, 32'h00000003);
        $display("test indirect port and map done");
        report_and_stop;
    end
endmodule // psr_regs_tb
bind psr_regs psr_regs_props u_props (
    .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rx_err_drop_enable, .link_drop_rx_err
);
